/* include/cid_pkg.sv */
// Constants for the control instruction decoder: opcodes, field positions, timing.
// Assumes a 16-bit program word path and one system clock of 10 MHz.
package cid_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [15:0] OP_MAP_DATA = 16'hCE04;
  localparam logic [15:0] OP_MAP_PROG = 16'hCE05;
  localparam logic [15:0] OP_POP_ACC = 16'hCE1D;
  localparam logic [15:0] OP_PUSH_ACC = 16'hCE1C;
  localparam logic [7:0] HI_LOAD_ST0 = 8'h50;
  localparam logic [7:0] HI_LOAD_ST1 = 8'h51;
  localparam logic [7:0] HI_SAVE_ST0 = 8'h78;
  localparam logic [7:0] HI_SAVE_ST1 = 8'h79;
  localparam logic [7:0] HI_POP_MEM = 8'h7A;
  localparam logic [7:0] HI_PUSH_MEM = 8'h54;
  localparam logic [7:0] HI_RPT_MEM = 8'h4B;
  localparam logic [7:0] HI_RPT_IMM = 8'hCB;
  localparam logic [7:0] HI_BIT_TEMP = 8'h57;
  // ==========================================================
  // Fields
  localparam int IND_BIT = 7;
  localparam int ADDR_W = 7;
  // ==========================================================
  // Timing: quarter-phases per machine cycle and strobe low length
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] BUS_STROBE_LOW_PH = 2'h2;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [3:0] {
    OPS_NONE, OPS_MAP_DATA, OPS_MAP_PROG, OPS_LOAD_ST0, OPS_LOAD_ST1,
    OPS_SAVE_ST0, OPS_SAVE_ST1, OPS_POP_ACC, OPS_POP_MEM, OPS_PUSH_MEM,
    OPS_PUSH_ACC, OPS_RPT_MEM, OPS_RPT_IMM, OPS_BIT_TEMP
  } cid_op_t;
endpackage : cid_pkg

/* logic/cid_phase_gen.sv */
// Quarter-phase generator: machine clock out and bus strobe.
// Assumes clk_sys is the input clock at four times the machine rate.
`timescale 1ns/1ps
module cid_phase_gen (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic busCycle,
  output logic [1:0] phase,
  output logic machineClockOut,
  output logic busStrobeN
);
  import cid_pkg::*;
  logic [1:0] phase_ff;
  logic clkOut_ff;
  logic strobeN_ff;
  // ==========================================================
  // Phase counter
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= (phase_ff == PHASE_LAST) ? 2'h0 : phase_ff + 2'h1;
    end
  end
  // Output high for phases 0..1, so one full period per four input clocks
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      clkOut_ff <= 1'b1;
    end else begin
      clkOut_ff <= (phase_ff == PHASE_LAST) || (phase_ff == 2'h0);
    end
  end
  // No wait states: low for two phases, high for the other two
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strobeN_ff <= 1'b1;
    end else begin
      strobeN_ff <= !(busCycle && (phase_ff + 2'h1) >= BUS_STROBE_LOW_PH);
    end
  end
  assign phase = phase_ff;
  assign machineClockOut = clkOut_ff;
  assign busStrobeN = strobeN_ff;
endmodule : cid_phase_gen

/* logic/cid_decoder.sv */
// Control instruction decoder top: registers a fetched word and its decoded select.
// Assumes fetch logic on clk_sys presents one word with a valid pulse.
`timescale 1ns/1ps
module cid_decoder (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fetchValid,
  input wire logic [15:0] fetchWord,
  input wire logic busCycle,
  output logic decValid,
  output cid_pkg::cid_op_t decOp,
  output logic indirectSel,
  output logic [6:0] addrField,
  output logic [7:0] immField,
  output logic usesMemory,
  output logic machineClockOut,
  output logic busStrobeN
);
  import cid_pkg::*;

  // ==========================================================
  // State
  logic valid_ff;
  cid_op_t op_ff;
  cid_op_t nxt_op;
  logic ind_ff;
  logic nxt_ind;
  logic [6:0] addr_ff;
  logic [6:0] nxt_addr;
  logic [7:0] imm_ff;
  logic [7:0] nxt_imm;
  logic mem_ff;
  logic nxt_mem;
  cid_op_t fixedOp;
  cid_op_t classOp;

  // ==========================================================
  // Fixed single words; the whole word must match
  function automatic cid_op_t decode_fixed(input logic [15:0] w);
    cid_op_t r;
    r = OPS_NONE;
    case (w)
      OP_MAP_DATA: begin
        r = OPS_MAP_DATA;
      end
      OP_MAP_PROG: begin
        r = OPS_MAP_PROG;
      end
      OP_POP_ACC: begin
        r = OPS_POP_ACC;
      end
      OP_PUSH_ACC: begin
        r = OPS_PUSH_ACC;
      end
      default: begin
        r = OPS_NONE;
      end
    endcase
    return r;
  endfunction : decode_fixed

  // ==========================================================
  // Upper-byte classes; low byte is operand or immediate
  function automatic cid_op_t decode_class(input logic [7:0] hi);
    cid_op_t r;
    r = OPS_NONE;
    case (hi)
      HI_LOAD_ST0: begin
        r = OPS_LOAD_ST0;
      end
      HI_LOAD_ST1: begin
        r = OPS_LOAD_ST1;
      end
      HI_SAVE_ST0: begin
        r = OPS_SAVE_ST0;
      end
      HI_SAVE_ST1: begin
        r = OPS_SAVE_ST1;
      end
      HI_POP_MEM: begin
        r = OPS_POP_MEM;
      end
      HI_PUSH_MEM: begin
        r = OPS_PUSH_MEM;
      end
      HI_RPT_MEM: begin
        r = OPS_RPT_MEM;
      end
      HI_RPT_IMM: begin
        r = OPS_RPT_IMM;
      end
      HI_BIT_TEMP: begin
        r = OPS_BIT_TEMP;
      end
      default: begin
        // Unknown bytes give no-op so execution units stay idle
        r = OPS_NONE;
      end
    endcase
    return r;
  endfunction : decode_class

  // ==========================================================
  // Ops with a data-memory operand in the low byte
  // Immediate and fixed words never touch data memory
  function automatic logic takes_memory(input cid_op_t op);
    logic m;
    m = 1'b0;
    case (op)
      OPS_LOAD_ST0, OPS_LOAD_ST1: begin
        m = 1'b1;
      end
      OPS_SAVE_ST0, OPS_SAVE_ST1: begin
        m = 1'b1;
      end
      OPS_POP_MEM, OPS_PUSH_MEM: begin
        m = 1'b1;
      end
      OPS_RPT_MEM, OPS_BIT_TEMP: begin
        m = 1'b1;
      end
      default: begin
        m = 1'b0;
      end
    endcase
    return m;
  endfunction : takes_memory

  // ==========================================================
  // Next values; a fixed word wins over any byte class
  always_comb begin
    fixedOp = decode_fixed(fetchWord);
    classOp = decode_class(fetchWord[15:8]);
    if (fixedOp != OPS_NONE) begin
      nxt_op = fixedOp;
    end else begin
      nxt_op = classOp;
    end
  end

  // Fields load for every word; cheaper than gating, and harmless
  always_comb begin
    nxt_ind = fetchWord[IND_BIT];
  end

  always_comb begin
    nxt_addr = fetchWord[ADDR_W-1:0];
  end

  always_comb begin
    nxt_imm = fetchWord[7:0];
  end

  always_comb begin
    nxt_mem = takes_memory(nxt_op);
  end

  // ==========================================================
  // Result valid, one cycle after the fetch strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= fetchValid;
    end
  end

  // Decoded op holds until the next fetched word
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      op_ff <= OPS_NONE;
    end else if (fetchValid) begin
      op_ff <= nxt_op;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ind_ff <= 1'b0;
    end else if (fetchValid) begin
      ind_ff <= nxt_ind;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_ff <= 7'h00;
    end else if (fetchValid) begin
      addr_ff <= nxt_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      imm_ff <= 8'h00;
    end else if (fetchValid) begin
      imm_ff <= nxt_imm;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mem_ff <= 1'b0;
    end else if (fetchValid) begin
      mem_ff <= nxt_mem;
    end
  end

  // ==========================================================
  // Clock and strobe timing
  // Phase count stays internal; units pace off the clock output
  cid_phase_gen u_phase (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .busCycle(busCycle),
    .phase(),
    .machineClockOut(machineClockOut),
    .busStrobeN(busStrobeN)
  );


  // ==========================================================
  // Outputs straight from flip-flops
  assign decValid = valid_ff;
  assign decOp = op_ff;
  assign indirectSel = ind_ff;
  assign addrField = addr_ff;
  assign immField = imm_ff;
  assign usesMemory = mem_ff;
endmodule : cid_decoder

/* verification/cid_decoder_assertions.sv */
// Checker on the cid_decoder ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module cid_decoder_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fetchValid,
  input wire logic [15:0] fetchWord,
  input wire logic busCycle,
  input wire logic decValid,
  input wire cid_pkg::cid_op_t decOp,
  input wire logic indirectSel,
  input wire logic [6:0] addrField,
  input wire logic [7:0] immField,
  input wire logic usesMemory,
  input wire logic machineClockOut,
  input wire logic busStrobeN
);
  import cid_pkg::*;
  logic [15:0] lastWord_ff;
  // ==========================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk_sys) lastWord_ff <= fetchWord;
  a_map_data: assert property (fetchValid && fetchWord == 16'hCE04 |=> decOp == OPS_MAP_DATA)
    else $error("map data miss");
  a_map_prog: assert property (fetchValid && fetchWord == 16'hCE05 |=> decOp == OPS_MAP_PROG)
    else $error("map prog miss");
  a_pop_acc: assert property (fetchValid && fetchWord == 16'hCE1D |=> decOp == OPS_POP_ACC)
    else $error("pop acc miss");
  a_imm_field: assert property (fetchValid |=> immField == lastWord_ff[7:0])
    else $error("imm field bad");
  a_ind_split: assert property (decValid |-> {indirectSel, addrField} == immField)
    else $error("field split bad");
  a_dec_pulse: assert property (fetchValid ##1 !fetchValid |-> decValid ##1 !decValid)
    else $error("valid pulse bad");
  a_mem_flag: assert property (fetchValid && fetchWord[15:8] == 8'h50 |=> usesMemory)
    else $error("memory flag miss");
  a_clk_quarter: assert property ($rose(machineClockOut) |=> machineClockOut ##1 !machineClockOut[*2] ##1 machineClockOut)
    else $error("clock ratio bad");
  a_strobe_len: assert property ($fell(busStrobeN) && busCycle |=> !busStrobeN ##1 busStrobeN[*2])
    else $error("strobe width bad");
  c_decode: cover property (decValid && decOp == OPS_MAP_DATA);
  c_strobe: cover property ($fell(busStrobeN));
  c_clock: cover property ($rose(machineClockOut));
endmodule : cid_decoder_chk
bind cid_decoder cid_decoder_chk u_cid_decoder_chk (.clk_sys(clk_sys), .resetn(resetn), .fetchValid(fetchValid),
  .fetchWord(fetchWord), .busCycle(busCycle), .decValid(decValid), .decOp(decOp), .indirectSel(indirectSel),
  .addrField(addrField), .immField(immField), .usesMemory(usesMemory), .machineClockOut(machineClockOut),
  .busStrobeN(busStrobeN));

/* verification/cid_fetch_model.sv */
// Fetch-side model presenting one program word per call.
// Assumes words are taken at the rising edge of clk_sys.
`timescale 1ns/1ps
module cid_fetch_model (
  input wire logic clk_sys,
  output logic fetchValid,
  output logic [15:0] fetchWord
);
  initial begin
    fetchValid = 1'b0;
    fetchWord = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    @(negedge clk_sys);
    fetchValid = 1'b1;
    fetchWord = w;
    @(negedge clk_sys);
    fetchValid = 1'b0;
    fetchWord = ~w; // Stale word must not pass for the last one
  endtask : send
endmodule : cid_fetch_model

/* verification/cid_decoder_tb_top.sv */
// Self-checking bench for cid_decoder.
// Assumes clk_sys at 10 MHz; inputs change at the falling edge.
`timescale 1ns/1ps
module cid_decoder_tb_top;
  import cid_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic busCycle = 1'b0;
  logic fetchValid, decValid, indirectSel, machineClockOut, busStrobeN, usesMemory;
  logic [15:0] fetchWord;
  logic [6:0] addrField;
  logic [7:0] immField;
  cid_op_t decOp;
  int badCount = 0;
  int testsRun = 0;
  always #50 clk_sys = ~clk_sys;
  cid_fetch_model u_cid_fetch_model (.clk_sys(clk_sys), .fetchValid(fetchValid), .fetchWord(fetchWord));
  cid_decoder u_cid_decoder (.clk_sys(clk_sys), .resetn(resetn), .fetchValid(fetchValid), .fetchWord(fetchWord),
    .busCycle(busCycle), .decValid(decValid), .decOp(decOp), .indirectSel(indirectSel), .addrField(addrField),
    .immField(immField), .usesMemory(usesMemory), .machineClockOut(machineClockOut), .busStrobeN(busStrobeN));
  // ==========================================
  // Checks and scenarios
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic giveVerdict();
    $display("checks %0d errors %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : giveVerdict
  task automatic t_decode();
    logic [15:0] w [14] = '{16'hCE04, 16'hCE05, 16'h5081, 16'h51FF, 16'h7800, 16'h797F, 16'hCE1D, 16'h7A80,
      16'h5401, 16'hCE1C, 16'h4B42, 16'hCB00, 16'h57FE, 16'h5500};
    logic [13:0] memExp = 14'h15BC;
    for (int i = 0; i < 14; i++) begin
      u_cid_fetch_model.send(w[i]);
      chk({decValid, 3'h0, decOp, immField}, {4'h8, (i < 13) ? 4'(i + 1) : 4'h0, w[i][7:0]});
      chk({8'h00, indirectSel, addrField}, {8'h00, w[i][7:0]});
      chk({15'h0, usesMemory}, {15'h0, memExp[i]});
    end
    @(negedge clk_sys);
    chk({15'h0, decValid}, 16'h0000);
    $display("decode test done");
  endtask : t_decode
  task automatic t_timing();
    logic [7:0] m, s;
    busCycle = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      m[i % 8] = machineClockOut;
      s[i % 8] = busStrobeN;
    end
    chk({15'h0, m[7:4] === m[3:0] && $countones(m[3:0]) == 2 && m[0] !== m[2]}, 16'h0001);
    chk({15'h0, s[7:4] === s[3:0] && $countones(s[3:0]) == 2 && s[0] !== s[2]}, 16'h0001);
    busCycle = 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(negedge clk_sys);
      s[i % 4] = busStrobeN;
    end
    chk({12'h000, s[3:0]}, 16'h000F);
    $display("timing test done");
  endtask : t_timing
  initial begin
    repeat (10) @(negedge clk_sys);
    chk({14'h0, machineClockOut, busStrobeN}, 16'h0003);
    resetn = 1'b1;
    t_decode();
    t_timing();
    giveVerdict();
  end
  initial begin
    #50000;
    badCount++;
    giveVerdict();
  end
endmodule : cid_decoder_tb_top
